// >>> shared/dac_ctrl_pkg.sv
// shared constants for the converter host interface control block
package dac_ctrl_pkg;

	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_PERIOD_NS    = 25;
	localparam int unsigned RST_PULSE_MIN_NS = 90;
	localparam int unsigned RST_PULSE_MAX_NS = 200;
	localparam int unsigned RST_MIN_CYC      =
		(RST_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned RST_MAX_CYC      =
		(RST_PULSE_MAX_NS / CLK_PERIOD_NS < 1) ? 1 :
		RST_PULSE_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned ACQ_TIME_NS      = 10000;
	localparam int unsigned ACQ_CYC          =
		(ACQ_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned PULSE_CNT_BITS   = 4;
	localparam int unsigned ACQ_CNT_BITS     = 9;

	// ------------------------------------------------------------------
	// channel and serial frame layout
	// ------------------------------------------------------------------
	localparam int unsigned CHAN_BITS    = 5;
	localparam int unsigned NUM_CHANNELS = 32;
	localparam int unsigned DATA_BITS    = 14;
	localparam int unsigned FRAME_BITS   = 20;
	localparam int unsigned FRAME_RD_POS = 19;
	localparam int unsigned FRAME_CH_MSB = 18;
	localparam int unsigned FRAME_CH_LSB = 14;
	localparam int unsigned COUNT_BITS   = 5;
	localparam logic [4:0]  FRAME_LAST   = 5'h13;
	localparam logic [4:0]  FRAME_FULL   = 5'h14;

	// ------------------------------------------------------------------
	// synchronised pin vector: positions and reset values
	// ------------------------------------------------------------------
	localparam int unsigned PIN_SEL    = 0;
	localparam int unsigned PIN_WR     = 1;
	localparam int unsigned PIN_OFS    = 2;
	localparam int unsigned PIN_STRAP  = 3;
	localparam int unsigned PIN_SIM    = 4;
	localparam int unsigned PIN_TRACK  = 5;
	localparam int unsigned PIN_WTGL   = 6;
	localparam int unsigned PIN_CH_LSB = 7;
	localparam int unsigned PIN_W      = 12;
	localparam logic [11:0] PIN_RST    = 12'hFA3;

	// ------------------------------------------------------------------
	// unconnected-pin flags and pull levels
	// ------------------------------------------------------------------
	localparam int unsigned FLT_SEL   = 0;
	localparam int unsigned FLT_WR    = 1;
	localparam int unsigned FLT_OFS   = 2;
	localparam int unsigned FLT_STRAP = 3;
	localparam int unsigned FLT_SIM   = 4;
	localparam int unsigned FLT_SDIN  = 5;
	localparam int unsigned FLT_CH    = 6;
	localparam int unsigned FLT_W     = 7;
	localparam logic        PULL_DOWN = 1'b0;
	localparam logic        PULL_UP   = 1'b1;

endpackage : dac_ctrl_pkg

// >>> logic/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
module pin_sync3 #(
	parameter int unsigned WIDTH           = 1,
	parameter logic [WIDTH-1:0] RST_VAL    = '0
) (
	// clock, reset and enable
	input  wire logic             clk_i,
	input  wire logic             rst_b_i,
	input  wire logic             en_i,
	// data
	input  wire logic [WIDTH-1:0] d_i,
	output logic      [WIDTH-1:0] q_o
);

	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	// stage1 feeds stage2 only; q follows once stage2 and stage3 agree
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			stage1 <= RST_VAL;
			stage2 <= RST_VAL;
			stage3 <= RST_VAL;
			q_o    <= RST_VAL;
		end else if (en_i) begin
			stage1 <= d_i;
			stage2 <= stage1;
			stage3 <= stage2;
			q_o    <= (~(stage2 ^ stage3) & stage3) | ((stage2 ^ stage3) & q_o);
		end
	end

endmodule : pin_sync3

// >>> logic/dac_host_interface_control.sv
// host interface control: serial and parallel access, track, busy
module dac_host_interface_control (
	// clock, reset, enable
	input  wire logic                                mclk_i,
	input  wire logic                                rst_b_i,
	input  wire logic                                clk_en_i,
	// host pins
	input  wire logic                                interface_strap_i,
	input  wire logic                                sel_b_i,
	input  wire logic                                wr_b_i,
	input  wire logic                                offset_sel_i,
	input  wire logic [dac_ctrl_pkg::CHAN_BITS-1:0]  channel_select_bits_i,
	input  wire logic                                sim_acquire_i,
	input  wire logic                                track_i,
	input  wire logic                                sclk_i,
	input  wire logic                                sdin_i,
	output logic                                     sdout_o,
	// pad ring: pins left unconnected
	input  wire logic [dac_ctrl_pkg::FLT_W-1:0]      pin_float_i,
	// channel register readback
	input  wire logic [dac_ctrl_pkg::DATA_BITS-1:0]  rd_data_i,
	output logic      [dac_ctrl_pkg::CHAN_BITS-1:0]  rd_channel_o,
	// channel access
	output logic                                     acc_stb_o,
	output logic                                     acc_serial_o,
	output logic      [dac_ctrl_pkg::CHAN_BITS-1:0]  acc_channel_o,
	output logic                                     acc_offset_o,
	output logic      [dac_ctrl_pkg::DATA_BITS-1:0]  acc_data_o,
	// acquisition control
	output logic                                     acq_start_o,
	output logic                                     acq_all_o,
	output logic      [dac_ctrl_pkg::CHAN_BITS-1:0]  acq_channel_o,
	output logic                                     busy_o,
	output logic                                     passthrough_o,
	// status
	output logic                                     serial_mode_o,
	output logic                                     device_reset_o
);

	typedef enum logic {ACQ_IDLE, ACQ_RUN} acq_state_t;

	function automatic logic pull(input logic v, input logic flt,
			input logic dflt);
		return flt ? dflt : v;
	endfunction : pull

	// ------------------------------------------------------------------
	// pin defaults from internal pulls
	// ------------------------------------------------------------------
	logic                                   sel_pin;
	logic                                   wr_pin;
	logic                                   ofs_pin;
	logic                                   strap_pin;
	logic                                   sim_pin;
	logic                                   sdin_pin;
	logic [dac_ctrl_pkg::CHAN_BITS-1:0]     ch_pin;

	assign sel_pin   = pull(sel_b_i, pin_float_i[dac_ctrl_pkg::FLT_SEL],
		dac_ctrl_pkg::PULL_DOWN);
	assign wr_pin    = pull(wr_b_i, pin_float_i[dac_ctrl_pkg::FLT_WR],
		dac_ctrl_pkg::PULL_DOWN);
	assign ofs_pin   = pull(offset_sel_i, pin_float_i[dac_ctrl_pkg::FLT_OFS],
		dac_ctrl_pkg::PULL_DOWN);
	assign strap_pin = pull(interface_strap_i,
		pin_float_i[dac_ctrl_pkg::FLT_STRAP], dac_ctrl_pkg::PULL_DOWN);
	assign sim_pin   = pull(sim_acquire_i, pin_float_i[dac_ctrl_pkg::FLT_SIM],
		dac_ctrl_pkg::PULL_DOWN);
	assign sdin_pin  = pull(sdin_i, pin_float_i[dac_ctrl_pkg::FLT_SDIN],
		dac_ctrl_pkg::PULL_UP);
	// address pins carry pull-ups
	assign ch_pin = pin_float_i[dac_ctrl_pkg::FLT_CH] ?
		{dac_ctrl_pkg::CHAN_BITS{dac_ctrl_pkg::PULL_UP}} :
		channel_select_bits_i;

	// ------------------------------------------------------------------
	// serial link, serial clock domain
	// ------------------------------------------------------------------
	logic [dac_ctrl_pkg::COUNT_BITS-1:0]  bit_cnt;
	logic [dac_ctrl_pkg::FRAME_BITS-1:0]  shift_in;
	logic [dac_ctrl_pkg::FRAME_BITS-1:0]  word_hold;
	logic                                 word_tgl;
	logic [dac_ctrl_pkg::DATA_BITS-1:0]   shift_out;
	logic [dac_ctrl_pkg::DATA_BITS-1:0]   rb_word;
	logic                                 frame_on;

	// frame sync high ends the frame; the strap keeps the port idle
	assign frame_on = !sel_pin && strap_pin;

	// counter is cleared by the frame signal itself, since the serial
	// clock may stop as soon as the frame ends
	always_ff @(negedge sclk_i or posedge sel_pin) begin
		if (sel_pin) begin
			bit_cnt <= '0;
		end else if (frame_on && bit_cnt != dac_ctrl_pkg::FRAME_FULL) begin
			bit_cnt <= bit_cnt + 1'b1;
		end
	end

	always_ff @(negedge sclk_i) begin
		if (frame_on && bit_cnt != dac_ctrl_pkg::FRAME_FULL) begin
			shift_in <= {shift_in[dac_ctrl_pkg::FRAME_BITS-2:0], sdin_pin};
		end
	end

	// whole word parked here and announced by a toggle
	always_ff @(negedge sclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			word_hold <= '0;
			word_tgl  <= 1'b0;
		end else if (frame_on && bit_cnt == dac_ctrl_pkg::FRAME_LAST) begin
			word_hold <= {shift_in[dac_ctrl_pkg::FRAME_BITS-2:0], sdin_pin};
			word_tgl  <= ~word_tgl;
		end
	end

	// readback word loads on the first rising edge of a frame, so the
	// serial clock must idle low between frames
	always_ff @(posedge sclk_i or posedge sel_pin) begin
		if (sel_pin) begin
			sdout_o   <= 1'b0;
			shift_out <= '0;
		end else if (!strap_pin) begin
			sdout_o   <= 1'b0;
			shift_out <= '0;
		end else if (bit_cnt == '0) begin
			sdout_o   <= rb_word[dac_ctrl_pkg::DATA_BITS-1];
			shift_out <= {rb_word[dac_ctrl_pkg::DATA_BITS-2:0], 1'b0};
		end else begin
			sdout_o   <= shift_out[dac_ctrl_pkg::DATA_BITS-1];
			shift_out <= {shift_out[dac_ctrl_pkg::DATA_BITS-2:0], 1'b0};
		end
	end

	// ------------------------------------------------------------------
	// reset release and pin synchronisation
	// ------------------------------------------------------------------
	logic [1:0]                      rst_pipe;
	logic                            rst_n;
	logic [dac_ctrl_pkg::PIN_W-1:0]  pin_vec;
	logic [dac_ctrl_pkg::PIN_W-1:0]  pin_q;
	logic [dac_ctrl_pkg::PIN_W-1:0]  pin_prev;

	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_pipe <= 2'h0;
		end else begin
			rst_pipe <= {rst_pipe[0], 1'b1};
		end
	end
	assign rst_n = rst_pipe[1];

	assign pin_vec = {ch_pin, word_tgl, track_i, sim_pin, strap_pin,
		ofs_pin, wr_pin, sel_pin};

	pin_sync3 #(
		.WIDTH   (dac_ctrl_pkg::PIN_W),
		.RST_VAL (dac_ctrl_pkg::PIN_RST)
	) u_pin_sync (
		.clk_i   (mclk_i),
		.rst_b_i (rst_n),
		.en_i    (clk_en_i),
		.d_i     (pin_vec),
		.q_o     (pin_q)
	);

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			pin_prev <= dac_ctrl_pkg::PIN_RST;
		end else if (clk_en_i) begin
			pin_prev <= pin_q;
		end
	end

	logic                                sel_s;
	logic                                wr_s;
	logic                                track_s;
	logic [dac_ctrl_pkg::CHAN_BITS-1:0]  ch_s;
	logic                                par_access;
	logic                                ser_word;
	logic                                track_rise;
	logic                                sim_rise;

	assign sel_s   = pin_q[dac_ctrl_pkg::PIN_SEL];
	assign wr_s    = pin_q[dac_ctrl_pkg::PIN_WR];
	assign track_s = pin_q[dac_ctrl_pkg::PIN_TRACK];
	assign ch_s    = pin_q[dac_ctrl_pkg::PIN_CH_LSB +: dac_ctrl_pkg::CHAN_BITS];

	// access opens when both strobes are low, counted once
	assign par_access = !serial_mode_o && !sel_s && !wr_s &&
		!(!pin_prev[dac_ctrl_pkg::PIN_SEL] && !pin_prev[dac_ctrl_pkg::PIN_WR]);
	assign ser_word   = serial_mode_o &&
		(pin_q[dac_ctrl_pkg::PIN_WTGL] != pin_prev[dac_ctrl_pkg::PIN_WTGL]);
	assign track_rise = track_s && !pin_prev[dac_ctrl_pkg::PIN_TRACK];
	assign sim_rise   = !serial_mode_o && pin_q[dac_ctrl_pkg::PIN_SIM] &&
		!pin_prev[dac_ctrl_pkg::PIN_SIM];

	// ------------------------------------------------------------------
	// track low pulse measurement and device reset
	// ------------------------------------------------------------------
	logic [dac_ctrl_pkg::PULSE_CNT_BITS-1:0]  low_cnt;
	logic                                     reset_hit;

	// both edges pass the same synchroniser, so width holds to a cycle
	assign reset_hit = track_rise &&
		low_cnt >= dac_ctrl_pkg::PULSE_CNT_BITS'(dac_ctrl_pkg::RST_MIN_CYC) &&
		low_cnt <= dac_ctrl_pkg::PULSE_CNT_BITS'(dac_ctrl_pkg::RST_MAX_CYC);

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			low_cnt <= '0;
		end else if (clk_en_i) begin
			if (track_s) begin
				low_cnt <= '0;
			end else if (low_cnt <=
					dac_ctrl_pkg::PULSE_CNT_BITS'(dac_ctrl_pkg::RST_MAX_CYC)) begin
				low_cnt <= low_cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			device_reset_o <= 1'b0;
		end else if (clk_en_i) begin
			device_reset_o <= reset_hit;
		end
	end

	// ------------------------------------------------------------------
	// mode and channel access
	// ------------------------------------------------------------------
	logic [dac_ctrl_pkg::CHAN_BITS-1:0]  word_ch;
	logic                                addr_event;
	logic [dac_ctrl_pkg::CHAN_BITS-1:0]  addr_ch;

	assign word_ch = word_hold[dac_ctrl_pkg::FRAME_CH_MSB:
		dac_ctrl_pkg::FRAME_CH_LSB];
	assign addr_event = par_access || ser_word;
	assign addr_ch    = serial_mode_o ? word_ch : ch_s;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			serial_mode_o <= 1'b0;
		end else if (clk_en_i) begin
			serial_mode_o <= pin_q[dac_ctrl_pkg::PIN_STRAP];
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			acc_stb_o     <= 1'b0;
			acc_serial_o  <= 1'b0;
			acc_channel_o <= '0;
			acc_offset_o  <= 1'b0;
			acc_data_o    <= '0;
		end else if (clk_en_i) begin
			acc_stb_o <= 1'b0;
			if (reset_hit) begin
				acc_channel_o <= '0;
				acc_offset_o  <= 1'b0;
				acc_data_o    <= '0;
			end else if (par_access) begin
				acc_stb_o     <= 1'b1;
				acc_serial_o  <= 1'b0;
				acc_channel_o <= ch_s;
				acc_offset_o  <= pin_q[dac_ctrl_pkg::PIN_OFS];
			end else if (ser_word && !word_hold[dac_ctrl_pkg::FRAME_RD_POS]) begin
				acc_stb_o     <= 1'b1;
				acc_serial_o  <= 1'b1;
				acc_channel_o <= word_ch;
				acc_offset_o  <= 1'b0;
				acc_data_o    <= word_hold[dac_ctrl_pkg::DATA_BITS-1:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// readback fetch
	// ------------------------------------------------------------------
	logic rd_pend;

	// rb_word is only sampled at the next frame start, long after it
	// settles, which is what makes the wide hand-over safe
	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			rd_channel_o <= '0;
			rd_pend      <= 1'b0;
			rb_word      <= '0;
		end else if (clk_en_i) begin
			rd_pend <= 1'b0;
			if (reset_hit) begin
				rd_channel_o <= '0;
				rb_word      <= '0;
			end else if (ser_word && word_hold[dac_ctrl_pkg::FRAME_RD_POS]) begin
				rd_channel_o <= word_ch;
				rd_pend      <= 1'b1;
			end else if (rd_pend) begin
				rb_word <= rd_data_i;
			end
		end
	end

	// ------------------------------------------------------------------
	// acquisition sequencing
	// ------------------------------------------------------------------
	acq_state_t                            acq_state;
	logic [dac_ctrl_pkg::ACQ_CNT_BITS-1:0] acq_cnt;
	logic [dac_ctrl_pkg::CHAN_BITS-1:0]    last_ch;
	logic                                  have_ch;
	logic                                  start_one;
	logic                                  start_all;

	// a request while busy is dropped, not queued
	assign start_one = acq_state == ACQ_IDLE && !reset_hit &&
		((addr_event && track_s) || (track_rise && have_ch));
	assign start_all = acq_state == ACQ_IDLE && !reset_hit && sim_rise;

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			last_ch <= '0;
			have_ch <= 1'b0;
		end else if (clk_en_i) begin
			if (reset_hit) begin
				last_ch <= '0;
				have_ch <= 1'b0;
			end else if (addr_event) begin
				last_ch <= addr_ch;
				have_ch <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			acq_state     <= ACQ_IDLE;
			acq_cnt       <= '0;
			acq_start_o   <= 1'b0;
			acq_all_o     <= 1'b0;
			acq_channel_o <= '0;
			busy_o        <= 1'b1;
		end else if (clk_en_i) begin
			acq_start_o <= 1'b0;
			unique case (acq_state)
				ACQ_IDLE: begin
					if (start_one || start_all) begin
						acq_state     <= ACQ_RUN;
						acq_cnt       <= dac_ctrl_pkg::ACQ_CNT_BITS'(
							dac_ctrl_pkg::ACQ_CYC - 1);
						acq_start_o   <= 1'b1;
						acq_all_o     <= start_all;
						acq_channel_o <= (addr_event && track_s) ? addr_ch : last_ch;
						busy_o        <= 1'b0;
					end
				end
				ACQ_RUN: begin
					if (reset_hit) begin
						acq_state <= ACQ_IDLE;
						acq_all_o <= 1'b0;
						busy_o    <= 1'b1;
					end else if (acq_cnt == '0) begin
						acq_state <= ACQ_IDLE;
						acq_all_o <= 1'b0;
						busy_o    <= 1'b1;
					end else begin
						acq_cnt <= acq_cnt - 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge mclk_i or negedge rst_n) begin
		if (!rst_n) begin
			passthrough_o <= 1'b0;
		end else if (clk_en_i) begin
			passthrough_o <= !track_s;
		end
	end

endmodule : dac_host_interface_control

// >>> verif/dac_host_interface_control_properties.sv
// port-level checks on the host interface control block
module dac_ctrl_checker (
	// clock and reset
	input wire logic mclk_i,
	input wire logic rst_b_i,
	// watched pins
	input wire logic sel_b_i,
	input wire logic track_i,
	input wire logic sdout_o,
	input wire logic acc_stb_o,
	input wire logic acc_serial_o,
	input wire logic acc_offset_o,
	input wire logic acq_start_o,
	input wire logic acq_all_o,
	input wire logic busy_o,
	input wire logic passthrough_o,
	input wire logic serial_mode_o,
	input wire logic device_reset_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);

	a_busy_start: assert property (acq_start_o |-> !busy_o)
		else $error("busy not low at acquisition start");
	a_busy_span: assert property ($fell(busy_o) |-> ##[398:401] busy_o)
		else $error("busy low span wrong");
	a_stb_pulse: assert property (acc_stb_o |=> !acc_stb_o)
		else $error("access strobe longer than one cycle");
	a_start_pulse: assert property (acq_start_o |=> !acq_start_o)
		else $error("start pulse longer than one cycle");
	a_reset_abort: assert property (device_reset_o |-> busy_o ##1 !device_reset_o)
		else $error("soft reset pulse or abort wrong");
	a_track_pass: assert property ($fell(track_i) |-> ##[3:7] passthrough_o)
		else $error("no passthrough after track low");
	a_sdout_idle: assert property (sel_b_i [*2] |-> !sdout_o)
		else $error("readback driven outside frame");
	a_serial_src: assert property (acc_stb_o |-> acc_serial_o == serial_mode_o)
		else $error("access source does not match mode");
	a_offset_par: assert property (acc_stb_o && acc_serial_o |-> !acc_offset_o)
		else $error("offset channel from serial access");
	a_all_start: assert property ($rose(acq_all_o) |-> acq_start_o && !busy_o)
		else $error("all-channel acquisition without start");

	c_ser_acc: cover property (acc_stb_o && acc_serial_o);
	c_ofs_acc: cover property (acc_stb_o && acc_offset_o);
	c_soft_rst: cover property (device_reset_o);
	c_all_acq: cover property ($rose(acq_all_o));
endmodule : dac_ctrl_checker

bind dac_host_interface_control dac_ctrl_checker dac_ctrl_checker_i (
	.mclk_i, .rst_b_i, .sel_b_i, .track_i, .sdout_o, .acc_stb_o,
	.acc_serial_o, .acc_offset_o, .acq_start_o, .acq_all_o, .busy_o,
	.passthrough_o, .serial_mode_o, .device_reset_o);

// >>> verif/serial_host_model.sv
// host side of the framed four-wire serial link
module serial_host_model (
	output logic      sclk_o,
	output logic      sdin_o,
	output logic      sync_b_o,
	input  wire logic sdout_i
);
	timeunit 1ns;
	timeprecision 1ps;
	// clock stands low and data rests at its pull-up level between frames
	// one rising sync edge after time zero clears the link logic
	initial begin
		sclk_o = 1'b0;
		sdin_o = 1'b1;
		sync_b_o = 1'b0;
		#1 sync_b_o = 1'b1;
	end
	// sends the top n bits of w msb first, rb gathers readback
	task automatic frame(input logic [19:0] w, input int n,
		output logic [13:0] rb);
		rb = '0;
		sync_b_o = 1'b0;
		#40;
		// 32 ns bit time, faster than a rated host clock; no bound in logic
		for (int i = 0; i < n; i++) begin
			sdin_o = w[19-i];
			#8 sclk_o = 1'b1;
			#16 sclk_o = 1'b0;
			if (i < 14) rb = {rb[12:0], sdout_i};
			#8;
		end
		#40 sync_b_o = 1'b1;
		sdin_o = 1'b1;
		// frame gap longer than the device needs
		#240;
	endtask : frame
endmodule : serial_host_model

// >>> verif/dac_host_interface_control_tb.sv
// self-checking bench for the host interface control block
module dac_host_interface_control_tb;
	timeunit 1ns;
	timeprecision 1ps;
	// ------------------------------------------------------------------
	// pins
	// ------------------------------------------------------------------
	logic        mclk_i = 1'b0;
	logic        rst_b_i = 1'b1;
	logic        clk_en_i = 1'b1;
	logic        interface_strap_i = 1'b0;
	logic        par_sel_b = 1'b1;
	logic        wr_b_i = 1'b1;
	logic        offset_sel_i = 1'b0;
	logic [4:0]  channel_select_bits_i = 5'h00;
	logic        sim_acquire_i = 1'b0;
	logic        track_i = 1'b1;
	logic [6:0]  pin_float_i = 7'h00;
	logic        sel_b_i, ser_sel_b, sclk_i, sdin_i, sdout_o;
	logic [13:0] rd_data_i, acc_data_o, m_data;
	logic [4:0]  rd_channel_o, acc_channel_o, acq_channel_o, m_ch, q_ch;
	logic        acc_stb_o, acc_serial_o, acc_offset_o, acq_start_o;
	logic        acq_all_o, busy_o, passthrough_o, serial_mode_o;
	logic        device_reset_o, m_ofs, m_ser;
	int          n_checks = 0, bad_count = 0, n_acc = 0, n_acq = 0;
	int          n_rst = 0;
	// register file stand-in seen through the readback channel
	assign rd_data_i = {4'h9, rd_channel_o, rd_channel_o};
	assign sel_b_i = par_sel_b & ser_sel_b;
	always #12.5 mclk_i = ~mclk_i;

	dac_host_interface_control dac_host_interface_control_i (
		.mclk_i, .rst_b_i, .clk_en_i, .interface_strap_i, .sel_b_i,
		.wr_b_i, .offset_sel_i, .channel_select_bits_i, .sim_acquire_i,
		.track_i, .sclk_i, .sdin_i, .sdout_o, .pin_float_i, .rd_data_i,
		.rd_channel_o, .acc_stb_o, .acc_serial_o, .acc_channel_o,
		.acc_offset_o, .acc_data_o, .acq_start_o, .acq_all_o,
		.acq_channel_o, .busy_o, .passthrough_o, .serial_mode_o,
		.device_reset_o);
	serial_host_model serial_host_model_i (.sclk_o(sclk_i),
		.sdin_o(sdin_i), .sync_b_o(ser_sel_b), .sdout_i(sdout_o));

	// pulses are caught mid-cycle, away from the launching edge
	always @(negedge mclk_i) begin
		if (acc_stb_o === 1'b1) begin
			n_acc++;
			{m_ch, m_ofs, m_ser, m_data} = {acc_channel_o, acc_offset_o,
				acc_serial_o, acc_data_o};
		end
		if (acq_start_o === 1'b1) begin
			n_acq++;
			q_ch = acq_channel_o;
		end
		if (device_reset_o === 1'b1) n_rst++;
	end
	// ------------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------------
	task automatic chk(input logic [19:0] got, exp, input string what);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t %s: %h not %h", $time, what, got,
				exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge mclk_i);
	endtask : cyc
	task automatic idle;
		for (int i = 0; i < 500 && busy_o !== 1'b1; i++) cyc(1);
		chk(busy_o, 1, "idle timeout");
	endtask : idle
	task automatic par_acc(input logic [4:0] c, input logic o);
		cyc(1);
		{channel_select_bits_i, offset_sel_i} = {c, o};
		{par_sel_b, wr_b_i} = 2'b00;
		cyc(8);
		{par_sel_b, wr_b_i} = 2'b11;
		cyc(6);
	endtask : par_acc
	// ------------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------------
	task automatic t_par;
		int a;
		for (int k = 0; k < 2; k++) begin
			a = n_acq;
			par_acc(k ? 5'h1F : 5'h00, k[0]);
			chk(m_ch, k ? 5'h1F : 5'h00, "channel");
			chk(m_ofs, k[0], "offset");
			chk(m_ser, 0, "source");
			chk(q_ch, k ? 5'h1F : 5'h00, "acq channel");
			chk(busy_o, 0, "busy");
			par_acc(5'h0A, 1'b0);
			chk(n_acq - a, 1, "start while busy");
			idle;
			chk(busy_o, 1, "busy end");
		end
		$display("parallel test done");
	endtask : t_par
	task automatic t_ser;
		logic [13:0] rb;
		int a;
		interface_strap_i = 1'b1;
		cyc(10);
		a = n_acc;
		serial_host_model_i.frame({1'b0, 5'h15, 14'h2A5C}, 20, rb);
		chk(n_acc - a, 1, "serial write");
		chk({m_ser, m_ch, m_data}, {1'b1, 5'h15, 14'h2A5C}, "word");
		serial_host_model_i.frame({1'b1, 5'h07, 14'h0000}, 20, rb);
		chk(rd_channel_o, 5'h07, "read channel");
		serial_host_model_i.frame(20'h00000, 14, rb);
		chk(rb, {4'h9, 5'h07, 5'h07}, "readback");
		chk(n_acc - a, 1, "short frame");
		interface_strap_i = 1'b0;
		cyc(10);
		serial_host_model_i.frame({1'b0, 5'h03, 14'h0001}, 20, rb);
		chk(n_acc - a, 1, "word in parallel mode");
		$display("serial test done");
	endtask : t_ser
	task automatic t_track;
		int a;
		idle;
		par_acc(5'h0C, 1'b0);
		idle;
		a = n_acq;
		track_i = 1'b0;
		cyc(20);
		chk(passthrough_o, 1, "passthrough");
		chk(n_acq - a, 0, "acq while low");
		track_i = 1'b1;
		cyc(8);
		chk(n_acq - a, 1, "acq on rise");
		chk(q_ch, 5'h0C, "acq channel on rise");
		chk(passthrough_o, 0, "passthrough end");
		idle;
		a = n_rst;
		track_i = 1'b0;
		cyc(5);
		track_i = 1'b1;
		cyc(8);
		chk(n_rst - a, 1, "soft reset");
		chk(busy_o, 1, "no acq on reset");
		chk({acc_channel_o, rd_channel_o}, 0, "cleared");
		track_i = 1'b0;
		cyc(20);
		track_i = 1'b1;
		cyc(8);
		chk(n_rst - a, 1, "long pulse");
		$display("track test done");
	endtask : t_track
	task automatic t_sim;
		idle;
		sim_acquire_i = 1'b1;
		cyc(8);
		chk({acq_all_o, busy_o}, 2'b10, "all channels");
		sim_acquire_i = 1'b0;
		idle;
		chk(acq_all_o, 0, "all end");
		$display("simultaneous test done");
	endtask : t_sim
	task automatic t_float;
		logic [13:0] rb;
		int a;
		a = n_acc;
		pin_float_i = 7'h43;
		cyc(10);
		chk(n_acc - a, 1, "floating strobes");
		chk(m_ch, 5'h1F, "floating address");
		pin_float_i = 7'h00;
		interface_strap_i = 1'b1;
		cyc(10);
		pin_float_i = 7'h20;
		serial_host_model_i.frame(20'h00000, 20, rb);
		chk(rd_channel_o, 5'h1F, "floating data");
		pin_float_i = 7'h08;
		cyc(10);
		chk(serial_mode_o, 0, "floating strap");
		pin_float_i = 7'h00;
		cyc(10);
		chk(serial_mode_o, 1, "strap high");
		idle;
		clk_en_i = 1'b0;
		interface_strap_i = 1'b0;
		cyc(10);
		chk(serial_mode_o, 1, "frozen by enable");
		clk_en_i = 1'b1;
		cyc(10);
		chk(serial_mode_o, 0, "strap low after enable");
		$display("floating pin test done");
	endtask : t_float
	// ------------------------------------------------------------------
	// run control
	// ------------------------------------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : wrap_up
	initial begin
		// reset edge after time zero so every reset branch sees it
		#1 rst_b_i = 1'b0;
		cyc(10);
		rst_b_i = 1'b1;
		cyc(10);
		t_par;
		t_ser;
		t_track;
		t_sim;
		t_float;
		wrap_up;
	end
	// whole run needs about 3000 cycles
	initial begin
		#1000000;
		bad_count++;
		$display("CHECK FAILED t=%0t watchdog expired", $time);
		wrap_up;
	end
endmodule : dac_host_interface_control_tb
